// ==== rtl/cycle_offset_timer.sv ====
// Cycle timer: offset count of cycle-clock ticks and a cycle count above it.
// Assumes tick is a one-cycle pulse per 24.576 MHz period from logic on clk.
module cycle_offset_timer
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic count_enable,
	input wire logic use_external,
	input wire logic external_edge,
	input wire logic load_valid,
	input wire logic [OFFSET_WIDTH-1:0] load_offset,
	output logic rollover,
	output logic [OFFSET_WIDTH-1:0] offset,
	output logic [CYCLE_COUNT_WIDTH-1:0] cycle_count
);

	logic roll_now;

	// Source of the rollover: internal wrap at the last tick, or the external edge.
	always_comb
	begin
		if (use_external)
			roll_now = count_enable && external_edge;
		else
			roll_now = count_enable && tick && (offset == OFFSET_LAST);
	end

	// Offset counts only while enabled; a received cycle start realigns it.
	always_ff @(posedge clk)
	begin
		if (rst)
			offset <= '0;
		else if (roll_now)
			offset <= '0;
		else if (load_valid)
			offset <= load_offset;
		else if (count_enable && tick && (offset != OFFSET_LAST))
			offset <= offset + 1'b1;
	end

	// Cycle count and the rollover pulse.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cycle_count <= '0;
			rollover <= 1'b0;
		end
		else
		begin
			rollover <= roll_now;
			if (roll_now)
				cycle_count <= cycle_count + 1'b1;
		end
	end

endmodule

// ==== rtl/link_control_fairness_regs.sv ====
// Link control and fairness register bank of a serial bus host controller link layer.
// Assumes a register port on clk, a cycle tick pulse from a local divider and a PHY on pins.
//
// Operation
// - Fairness register bits 31 to 8 read as zero.
// - Eight-bit limit on priority requests per fairness interval, never exceeded.
// - Link control writes decode at a set address and a clear address.
// - Ones written at set address set flags; ones at clear address clear.
// - Reserved link control bits 31-23, 19-11 and 8-0 read as zero.
// - Rollover select one rolls the cycle timer on the external cycle input.
// - Rollover select zero rolls the timer after 3072 cycle-clock ticks.
// - Cycle master and root PHY emit a cycle start at each rollover.
// - Cycle master zero accepts received cycle starts to synchronise the timer.
// - Cycle master flag clears when the overlong cycle flag becomes set.
// - Setting cycle master is ignored while the overlong cycle flag is set.
// - Offset count enable advances the offset per tick; zero holds it except for a received cycle start load.
// - PHY packets accepted when flag set and async receive context enabled.
// - Self-ID packets accepted when the self-ID receive flag is set.
module link_control_fairness_regs
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic cycle_tick,
	input wire logic external_cycle_input,
	input wire logic phy_is_root,
	input wire logic overlong_cycle_flag,
	input wire logic cycle_start_rx_valid,
	input wire logic [OFFSET_WIDTH-1:0] cycle_start_rx_offset,
	input wire logic async_receive_enable,
	input wire logic phy_packet_valid,
	input wire logic self_id_packet_valid,
	input wire logic fairness_interval_start,
	input wire logic priority_request_want,
	output logic priority_request,
	output logic cycle_start_send,
	output logic phy_packet_accept,
	output logic self_id_packet_accept,
	output logic rollover_select,
	output logic cycle_master_enable,
	output logic offset_count_enable,
	output logic phy_packet_receive_enable,
	output logic self_id_receive_enable
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [PRIORITY_LIMIT_WIDTH-1:0] priority_limit;
	logic [PRIORITY_LIMIT_WIDTH-1:0] priority_used;
	logic ext_sync1;
	logic ext_sync2;
	logic ext_prev;
	logic ext_edge;
	logic overlong_prev;
	logic overlong_rise;
	logic set_write;
	logic clear_write;
	logic timer_rollover;
	logic timer_load;
	logic [OFFSET_WIDTH-1:0] timer_offset;
	logic [CYCLE_COUNT_WIDTH-1:0] timer_cycles;
	logic [7:0] phy_packet_count;
	logic [7:0] self_id_count;
	logic [31:0] next_rdata;

	// Places each link control flag at its bit and leaves every other bit zero.
	function automatic logic [31:0] link_word(
		input logic src,
		input logic master,
		input logic count,
		input logic phy_pkt,
		input logic self_id
	);
		logic [31:0] w;
		w = READ_ZERO;
		w[ROLLOVER_SELECT_BIT] = src;
		w[CYCLE_MASTER_BIT] = master;
		w[OFFSET_COUNT_BIT] = count;
		w[PHY_PACKET_BIT] = phy_pkt;
		w[SELF_ID_BIT] = self_id;
		return w;
	endfunction

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------

	// The two link control addresses share one set of flags.
	assign set_write = wr && (addr == LINK_SET_OFFSET);
	assign clear_write = wr && (addr == LINK_CLEAR_OFFSET);

	// Fairness limit: only the low byte is stored.
	always_ff @(posedge clk)
	begin
		if (rst)
			priority_limit <= PRIORITY_LIMIT_RESET;
		else if (wr && (addr == FAIRNESS_OFFSET))
			priority_limit <= wdata[PRIORITY_LIMIT_WIDTH-1:0];
	end

	// ------------------------------------------------------------
	// Input synchronisation and edge detection
	// ------------------------------------------------------------

	// The external cycle input is a pin, so it passes two flip-flops first.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ext_sync1 <= 1'b0;
			ext_sync2 <= 1'b0;
			ext_prev <= 1'b0;
		end
		else
		begin
			ext_sync1 <= external_cycle_input;
			ext_sync2 <= ext_sync1;
			ext_prev <= ext_sync2;
		end
	end

	// A rising edge of the synchronised input marks one external rollover.
	// The previous-value flop starts low like the idle pin, so reset makes no false edge.
	assign ext_edge = ext_sync2 && !ext_prev;

	// The overlong flag comes from the event register on this clock.
	always_ff @(posedge clk)
	begin
		if (rst)
			overlong_prev <= 1'b0;
		else
			overlong_prev <= overlong_cycle_flag;
	end

	// The clear acts on the moment the event becomes set, not on its level.
	// A flag already high when reset ends counts as a fresh event and drops master.
	assign overlong_rise = overlong_cycle_flag && !overlong_prev;

	// ------------------------------------------------------------
	// Link control flags
	// ------------------------------------------------------------

	// Rollover source select.
	always_ff @(posedge clk)
	begin
		if (rst)
			rollover_select <= FLAG_RESET;
		else if (set_write && wdata[ROLLOVER_SELECT_BIT])
			rollover_select <= 1'b1;
		else if (clear_write && wdata[ROLLOVER_SELECT_BIT])
			rollover_select <= 1'b0;
	end

	// Cycle master flag: an overlong cycle drops it and blocks software sets.
	always_ff @(posedge clk)
	begin
		if (rst)
			cycle_master_enable <= FLAG_RESET;
		else if (overlong_rise)
			cycle_master_enable <= 1'b0;
		else if (set_write && wdata[CYCLE_MASTER_BIT] && !overlong_cycle_flag)
			cycle_master_enable <= 1'b1;
		else if (clear_write && wdata[CYCLE_MASTER_BIT])
			cycle_master_enable <= 1'b0;
	end

	// Offset count enable.
	always_ff @(posedge clk)
	begin
		if (rst)
			offset_count_enable <= FLAG_RESET;
		else if (set_write && wdata[OFFSET_COUNT_BIT])
			offset_count_enable <= 1'b1;
		else if (clear_write && wdata[OFFSET_COUNT_BIT])
			offset_count_enable <= 1'b0;
	end

	// PHY packet receive enable.
	always_ff @(posedge clk)
	begin
		if (rst)
			phy_packet_receive_enable <= FLAG_RESET;
		else if (set_write && wdata[PHY_PACKET_BIT])
			phy_packet_receive_enable <= 1'b1;
		else if (clear_write && wdata[PHY_PACKET_BIT])
			phy_packet_receive_enable <= 1'b0;
	end

	// Self-ID receive enable; software must have set up the buffer pointer first.
	always_ff @(posedge clk)
	begin
		if (rst)
			self_id_receive_enable <= FLAG_RESET;
		else if (set_write && wdata[SELF_ID_BIT])
			self_id_receive_enable <= 1'b1;
		else if (clear_write && wdata[SELF_ID_BIT])
			self_id_receive_enable <= 1'b0;
	end

	// ------------------------------------------------------------
	// Cycle timer and cycle start generation
	// ------------------------------------------------------------

	// Received cycle starts realign the offset only while this node is not master.
	// A rollover in the same cycle wins over the load inside the timer.
	assign timer_load = cycle_start_rx_valid && !cycle_master_enable;

	cycle_offset_timer timer
	(
		.clk(clk),
		.rst(rst),
		.tick(cycle_tick),
		.count_enable(offset_count_enable),
		.use_external(rollover_select),
		.external_edge(ext_edge),
		.load_valid(timer_load),
		.load_offset(cycle_start_rx_offset),
		.rollover(timer_rollover),
		.offset(timer_offset),
		.cycle_count(timer_cycles)
	);

	// A cycle start goes out on each rollover while this node is root and master.
	always_ff @(posedge clk)
	begin
		if (rst)
			cycle_start_send <= 1'b0;
		else
			cycle_start_send <= timer_rollover && cycle_master_enable && phy_is_root;
	end

	// ------------------------------------------------------------
	// Receive filtering
	// ------------------------------------------------------------

	// PHY packets need their flag and an enabled async receive context.
	always_ff @(posedge clk)
	begin
		if (rst)
			phy_packet_accept <= 1'b0;
		else
			phy_packet_accept <= phy_packet_valid && phy_packet_receive_enable
				&& async_receive_enable;
	end

	// Self-ID packets depend only on their own flag.
	always_ff @(posedge clk)
	begin
		if (rst)
			self_id_packet_accept <= 1'b0;
		else
			self_id_packet_accept <= self_id_packet_valid && self_id_receive_enable;
	end

	// Counts of accepted packets, wrapping, for software to watch traffic.
	// Each count is eight bits wide, so software must read it often enough to see wraps.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phy_packet_count <= 8'h00;
			self_id_count <= 8'h00;
		end
		else
		begin
			if (phy_packet_accept)
				phy_packet_count <= phy_packet_count + 8'h01;
			if (self_id_packet_accept)
				self_id_count <= self_id_count + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Priority request limiting
	// ------------------------------------------------------------

	// A request wanted in the cycle that opens an interval is dropped, not deferred.
	priority_request_limiter #(
		.WIDTH(PRIORITY_LIMIT_WIDTH)
	) limiter
	(
		.clk(clk),
		.rst(rst),
		.limit(priority_limit),
		.interval_start(fairness_interval_start),
		.want(priority_request_want),
		.grant(priority_request),
		.used(priority_used)
	);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------

	// Read data selection; unmapped addresses read as zero.
	always_comb
	begin
		next_rdata = READ_ZERO;
		unique case (addr)
			FAIRNESS_OFFSET:
				next_rdata[PRIORITY_LIMIT_WIDTH-1:0] = priority_limit;
			LINK_SET_OFFSET, LINK_CLEAR_OFFSET:
				next_rdata = link_word(rollover_select, cycle_master_enable,
					offset_count_enable, phy_packet_receive_enable,
					self_id_receive_enable);
			CYCLE_STATUS_OFFSET:
			begin
				next_rdata[OFFSET_WIDTH-1:0] = timer_offset;
				next_rdata[CYCLE_COUNT_POS +: CYCLE_COUNT_WIDTH] = timer_cycles;
			end
			RECEIVE_COUNT_OFFSET:
			begin
				next_rdata[7:0] = phy_packet_count;
				next_rdata[15:8] = self_id_count;
			end
			FAIRNESS_STATUS_OFFSET:
				next_rdata[PRIORITY_LIMIT_WIDTH-1:0] = priority_used;
			default:
				next_rdata = READ_ZERO;
		endcase
	end

	// Read data stand for exactly the cycle after the read strobe.
	// Returning zero outside that cycle keeps stale data off the shared read bus.
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata <= READ_ZERO;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= READ_ZERO;
	end

endmodule

// ==== rtl/link_regs_pkg.sv ====
// Package of offsets, field positions, reset values and counts for the link control bank.
// Assumes a byte-addressed register port with 32-bit data and one clock domain.
package link_regs_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FAIRNESS_OFFSET = 8'hdc;
	localparam logic [7:0] LINK_SET_OFFSET = 8'he0;
	localparam logic [7:0] LINK_CLEAR_OFFSET = 8'he4;
	localparam logic [7:0] CYCLE_STATUS_OFFSET = 8'hf0;
	localparam logic [7:0] RECEIVE_COUNT_OFFSET = 8'hf4;
	localparam logic [7:0] FAIRNESS_STATUS_OFFSET = 8'hf8;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int PRIORITY_LIMIT_WIDTH = 8;
	localparam int ROLLOVER_SELECT_BIT = 22;
	localparam int CYCLE_MASTER_BIT = 21;
	localparam int OFFSET_COUNT_BIT = 20;
	localparam int PHY_PACKET_BIT = 10;
	localparam int SELF_ID_BIT = 9;
	localparam int OFFSET_WIDTH = 12;
	localparam int CYCLE_COUNT_WIDTH = 13;
	localparam int CYCLE_COUNT_POS = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PRIORITY_LIMIT_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// Cycle timer counts, in ticks of the 24.576 MHz cycle clock
	// ------------------------------------------------------------
	localparam int CYCLE_TICKS = 3072;
	localparam logic [11:0] OFFSET_LAST = 12'(CYCLE_TICKS - 1);

endpackage

// ==== rtl/priority_request_limiter.sv ====
// Limits priority arbitration requests to a programmed count per fairness interval.
// Assumes interval_start and want are one-cycle pulses from logic on clk.
module priority_request_limiter
	import link_regs_pkg::*;
#(
	parameter int WIDTH = PRIORITY_LIMIT_WIDTH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] limit,
	input wire logic interval_start,
	input wire logic want,
	output logic grant,
	output logic [WIDTH-1:0] used
);

	logic allowed;

	// A request is allowed only while the used count is below the limit.
	assign allowed = want && (used < limit);

	// Count granted requests; a new interval restarts the count.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			used <= '0;
			grant <= 1'b0;
		end
		else
		begin
			grant <= allowed && !interval_start;
			if (interval_start)
				used <= '0;
			else if (allowed)
				used <= used + 1'b1;
		end
	end

endmodule

// ==== tb/link_control_fairness_regs_bench.sv ====
// Self-checking bench of the link control bank with a PHY model.
// Assumes the package, the design, the checker and phy_model compiled first.
module link_control_fairness_regs_bench
	import link_regs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, cycle_tick = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic external_cycle_input = 1'b0, overlong_cycle_flag = 1'b0, root_req = 1'b0;
	logic async_receive_enable = 1'b0, fairness_interval_start = 1'b0;
	logic priority_request_want = 1'b0;
	logic [1:0] event_req = 2'd0;
	logic [OFFSET_WIDTH-1:0] event_offset = '0, cycle_start_rx_offset;
	logic phy_is_root, phy_packet_valid, self_id_packet_valid, cycle_start_rx_valid;
	logic priority_request, cycle_start_send, phy_packet_accept, self_id_packet_accept;
	logic rollover_select, cycle_master_enable, offset_count_enable;
	logic phy_packet_receive_enable, self_id_receive_enable;
	int mismatches = 0, total_checks = 0, starts_seen, grants_seen, base;

	link_control_fairness_regs link_control_fairness_regs_inst
	(
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.cycle_tick(cycle_tick), .external_cycle_input(external_cycle_input),
		.phy_is_root(phy_is_root), .overlong_cycle_flag(overlong_cycle_flag),
		.cycle_start_rx_valid(cycle_start_rx_valid),
		.cycle_start_rx_offset(cycle_start_rx_offset),
		.async_receive_enable(async_receive_enable), .phy_packet_valid(phy_packet_valid),
		.self_id_packet_valid(self_id_packet_valid),
		.fairness_interval_start(fairness_interval_start),
		.priority_request_want(priority_request_want), .priority_request(priority_request),
		.cycle_start_send(cycle_start_send), .phy_packet_accept(phy_packet_accept),
		.self_id_packet_accept(self_id_packet_accept), .rollover_select(rollover_select),
		.cycle_master_enable(cycle_master_enable), .offset_count_enable(offset_count_enable),
		.phy_packet_receive_enable(phy_packet_receive_enable),
		.self_id_receive_enable(self_id_receive_enable)
	);
	phy_model phy_model_inst
	(
		.clk(clk), .rst(rst), .root_req(root_req), .event_req(event_req),
		.event_offset(event_offset), .cycle_start_send(cycle_start_send),
		.priority_request(priority_request), .phy_is_root(phy_is_root),
		.phy_packet_valid(phy_packet_valid), .self_id_packet_valid(self_id_packet_valid),
		.cycle_start_rx_valid(cycle_start_rx_valid),
		.cycle_start_rx_offset(cycle_start_rx_offset),
		.starts_seen(starts_seen), .grants_seen(grants_seen)
	);

	always #12.5 clk = ~clk;

	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] mask = 32'hffff_ffff);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(name, exp & mask, rdata & mask);
	endtask

	task automatic phy_event(input logic [1:0] k, input logic [11:0] off = 12'h000);
		@(posedge clk);
		event_req <= k;
		event_offset <= off;
		@(posedge clk);
		event_req <= 2'd0;
		repeat (3) @(posedge clk);
	endtask

	task automatic run_ticks(input int n);
		@(posedge clk);
		cycle_tick <= 1'b1;
		repeat (n) @(posedge clk);
		cycle_tick <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog that ends a hung run as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd_chk("fairness reset", FAIRNESS_OFFSET, 32'h0);
		rd_chk("link reset", LINK_SET_OFFSET, 32'h0);
		wr_reg(FAIRNESS_OFFSET, 32'hffff_ffff);
		rd_chk("fairness rw", FAIRNESS_OFFSET, 32'h0000_00ff);
		wr_reg(8'h10, 32'hffff_ffff);
		rd_chk("unmapped", 8'h10, 32'h0);
		wr_reg(LINK_SET_OFFSET, 32'hffff_ffff);
		rd_chk("link set", LINK_CLEAR_OFFSET, 32'h0070_0600);
		wr_reg(LINK_CLEAR_OFFSET, 32'h0020_0400);
		rd_chk("link clear", LINK_SET_OFFSET, 32'h0050_0200);
		wr_reg(LINK_CLEAR_OFFSET, 32'hffff_ffff);
		rd_chk("link empty", LINK_SET_OFFSET, 32'h0);
		// Overlong cycle clears the master flag and blocks setting it.
		wr_reg(LINK_SET_OFFSET, 32'h0020_0000);
		@(posedge clk);
		overlong_cycle_flag <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("master cleared", 32'h0, {31'h0, cycle_master_enable});
		wr_reg(LINK_SET_OFFSET, 32'h0020_0000);
		chk("master blocked", 32'h0, {31'h0, cycle_master_enable});
		@(posedge clk);
		overlong_cycle_flag <= 1'b0;
		wr_reg(LINK_SET_OFFSET, 32'h0020_0000);
		chk("master set", 32'h1, {31'h0, cycle_master_enable});
		// Priority grants per interval, limit zero and three.
		for (int l = 0; l <= 3; l += 3)
		begin
			wr_reg(FAIRNESS_OFFSET, 32'(l));
			base = grants_seen;
			@(posedge clk);
			fairness_interval_start <= 1'b1;
			@(posedge clk);
			fairness_interval_start <= 1'b0;
			priority_request_want <= 1'b1;
			repeat (6) @(posedge clk);
			priority_request_want <= 1'b0;
			repeat (2) @(posedge clk);
			chk("grants", 32'(l), 32'(grants_seen - base));
			rd_chk("used", FAIRNESS_STATUS_OFFSET, 32'(l), 32'h0000_00ff);
		end
		// Packets refused while flags or the receive context are off.
		phy_event(2'd1);
		phy_event(2'd2);
		wr_reg(LINK_SET_OFFSET, 32'h0000_0600);
		phy_event(2'd1);
		async_receive_enable <= 1'b1;
		phy_event(2'd1);
		phy_event(2'd2);
		rd_chk("accepted", RECEIVE_COUNT_OFFSET, 32'h0000_0101, 32'h0000_ffff);
		// Internal rollover twice, then hold, then external rollover.
		@(posedge clk);
		root_req <= 1'b1;
		wr_reg(LINK_SET_OFFSET, 32'h0030_0000);
		base = starts_seen;
		run_ticks(2 * CYCLE_TICKS + 5);
		chk("starts", 32'h2, 32'(starts_seen - base));
		rd_chk("timer", CYCLE_STATUS_OFFSET, 32'h0002_0005);
		wr_reg(LINK_CLEAR_OFFSET, 32'h0010_0000);
		run_ticks(10);
		rd_chk("timer hold", CYCLE_STATUS_OFFSET, 32'h0002_0005);
		wr_reg(LINK_SET_OFFSET, 32'h0050_0000);
		@(posedge clk);
		external_cycle_input <= 1'b1;
		repeat (6) @(posedge clk);
		external_cycle_input <= 1'b0;
		repeat (2) @(posedge clk);
		chk("external start", 32'h3, 32'(starts_seen - base));
		rd_chk("external", CYCLE_STATUS_OFFSET, 32'h0003_0000);
		// Received cycle start loads the offset when not master.
		wr_reg(LINK_CLEAR_OFFSET, 32'h0070_0000);
		phy_event(2'd3, 12'h123);
		rd_chk("sync", CYCLE_STATUS_OFFSET, 32'h0000_0123, 32'h0000_0fff);
		final_report();
	end
endmodule

// ==== tb/link_regs_sva.sv ====
// Concurrent checks on the ports of the link control bank.
// Assumes one clock domain and a synchronous active-high reset.
module link_regs_sva
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic phy_is_root,
	input wire logic overlong_cycle_flag,
	input wire logic async_receive_enable,
	input wire logic phy_packet_valid,
	input wire logic self_id_packet_valid,
	input wire logic fairness_interval_start,
	input wire logic priority_request,
	input wire logic cycle_start_send,
	input wire logic phy_packet_accept,
	input wire logic self_id_packet_accept,
	input wire logic cycle_master_enable,
	input wire logic offset_count_enable,
	input wire logic phy_packet_receive_enable,
	input wire logic self_id_receive_enable
);
	timeunit 1ns;
	timeprecision 100ps;

	// --------------------------------
	// Helper logic
	// --------------------------------
	logic [7:0] lim;
	logic [7:0] cnt;
	wire set_wr = wr && addr == LINK_SET_OFFSET;
	wire clr_wr = wr && addr == LINK_CLEAR_OFFSET;

	// Mirrors the limit and counts grants since the last interval start.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			lim <= 8'h00;
			cnt <= 8'h00;
		end
		else
		begin
			if (wr && addr == FAIRNESS_OFFSET)
				lim <= wdata[7:0];
			cnt <= fairness_interval_start ? 8'h00 : cnt + 8'(priority_request);
		end
	end

	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	// --------------------------------
	// Assertions
	// --------------------------------
	AST_FAIR_RSVD: assert property (rd && addr == FAIRNESS_OFFSET
		|=> rdata[31:8] == 24'h000000) else $error("fairness upper bits not zero");
	AST_LINK_RSVD: assert property (rd
		&& (addr == LINK_SET_OFFSET || addr == LINK_CLEAR_OFFSET)
		|=> {rdata[31:23], rdata[19:11], rdata[8:0]} == 27'h0) else $error("link reserved bits set");
	AST_SET_FLAG: assert property (set_wr && wdata[SELF_ID_BIT]
		|=> self_id_receive_enable) else $error("set write did not set flag");
	AST_CLEAR_FLAG: assert property (clr_wr && wdata[PHY_PACKET_BIT]
		|=> !phy_packet_receive_enable) else $error("clear write did not clear flag");
	AST_FLAG_HOLD: assert property (!set_wr && !clr_wr && !$past(rst)
		|=> $stable({offset_count_enable, phy_packet_receive_enable, self_id_receive_enable}))
		else $error("flag moved without a write");
	AST_MASTER_CLEAR: assert property ($rose(overlong_cycle_flag)
		|=> !cycle_master_enable) else $error("master kept after overlong cycle");
	AST_MASTER_BLOCK: assert property (set_wr && wdata[CYCLE_MASTER_BIT]
		&& overlong_cycle_flag && !cycle_master_enable
		|=> !cycle_master_enable) else $error("master set while blocked");
	AST_PHY_ACCEPT: assert property (phy_packet_valid && phy_packet_receive_enable
		&& async_receive_enable |=> phy_packet_accept) else $error("phy packet not accepted");
	AST_SID_ACCEPT: assert property (self_id_packet_valid && self_id_receive_enable
		|=> self_id_packet_accept) else $error("self-id packet not accepted");
	AST_LIMIT: assert property (priority_request
		|-> cnt < lim) else $error("priority limit exceeded");
	AST_SEND_MASTER: assert property (cycle_start_send
		|-> $past(cycle_master_enable) && $past(phy_is_root))
		else $error("cycle start without master");

	cover property (cycle_start_send);
	cover property (priority_request ##1 priority_request);
	cover property ($fell(cycle_master_enable));
endmodule

bind link_control_fairness_regs link_regs_sva link_regs_sva_inst
(
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.phy_is_root(phy_is_root), .overlong_cycle_flag(overlong_cycle_flag),
	.async_receive_enable(async_receive_enable), .phy_packet_valid(phy_packet_valid),
	.self_id_packet_valid(self_id_packet_valid),
	.fairness_interval_start(fairness_interval_start),
	.priority_request(priority_request), .cycle_start_send(cycle_start_send),
	.phy_packet_accept(phy_packet_accept), .self_id_packet_accept(self_id_packet_accept),
	.cycle_master_enable(cycle_master_enable), .offset_count_enable(offset_count_enable),
	.phy_packet_receive_enable(phy_packet_receive_enable),
	.self_id_receive_enable(self_id_receive_enable)
);

// ==== tb/phy_model.sv ====
// Model of the PHY on the far side: root status, arriving packets and cycle starts.
// Assumes the bench asks for one event at a time by a one-cycle request.
module phy_model
	import link_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic root_req,
	input wire logic [1:0] event_req,
	input wire logic [OFFSET_WIDTH-1:0] event_offset,
	input wire logic cycle_start_send,
	input wire logic priority_request,
	output logic phy_is_root = 1'b0,
	output logic phy_packet_valid = 1'b0,
	output logic self_id_packet_valid = 1'b0,
	output logic cycle_start_rx_valid = 1'b0,
	output logic [OFFSET_WIDTH-1:0] cycle_start_rx_offset = '0,
	output int starts_seen = 0,
	output int grants_seen = 0
);
	timeunit 1ns;
	timeprecision 100ps;

	// Events leave one cycle after the request; the offset bus toggles when idle.
	always @(posedge clk)
	begin
		phy_is_root <= !rst && root_req;
		phy_packet_valid <= !rst && event_req == 2'd1;
		self_id_packet_valid <= !rst && event_req == 2'd2;
		cycle_start_rx_valid <= !rst && event_req == 2'd3;
		cycle_start_rx_offset <= event_req == 2'd3 ? event_offset : ~cycle_start_rx_offset;
		starts_seen <= starts_seen + int'(cycle_start_send);
		grants_seen <= grants_seen + int'(priority_request);
	end
endmodule
